// ==== src/pric_arb_if.sv ====
// Candidate set and winner of one priority arbitration.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pric_arb_if #(
	parameter int N = pric_pkg::NUM_SRC
);
	logic [N-1:0] cand;
	logic [N-1:0][pric_pkg::LEVEL_W-1:0] lvl;
	logic found;
	logic [pric_pkg::LEVEL_W-1:0] best_lvl;
	logic [pric_pkg::VEC_W-1:0] best_idx;

	modport arb (input cand, input lvl, output found, output best_lvl,
		output best_idx);
	modport user (output cand, output lvl, input found, input best_lvl,
		input best_idx);
endinterface

// ==== src/pric_arbiter.sv ====
// Combinational pick of the highest level candidate.
// Assumes index order equals vector order.
`timescale 1ns/1ps
module pric_arbiter #(
	parameter int N = pric_pkg::NUM_SRC
) (
	pric_arb_if.arb arb // Candidates in, winner out
);
	import pric_pkg::*;

	logic found;
	logic [LEVEL_W-1:0] best;
	logic [VEC_W-1:0] idx;

	always_comb
	begin
		found = 1'b0;
		best = NO_LEVEL;
		idx = '0;
		// Lower index wins a tie by scanning downwards with >=
		for (int i = N - 1; i >= 0; i--)
		begin
			if (arb.cand[i] && (!found || arb.lvl[i] >= best)) // [RULE_20]
			begin
				found = 1'b1;
				best = arb.lvl[i];
				idx = VEC_W'(i);
			end
		end
		arb.found = found;
		arb.best_lvl = best;
		arb.best_idx = idx;
	end

endmodule

// ==== src/pric_pkg.sv ====
// Shared constants of the priority interrupt controller.
// Assumes a 32-bit AXI4-Lite register bus with 16-bit registers.
package pric_pkg;

	localparam int ADDR_W = 6;
	localparam int LEVEL_W = 4;
	localparam int VEC_W = 7;
	localparam int PRIO_W = 3;
	localparam int NUM_USER = 3;
	localparam int NUM_TRAP = 4;
	localparam int NUM_SRC = NUM_TRAP + NUM_USER;
	localparam int TIMED_DISABLE_INSTR_W = 14;
	localparam int STACK_DEPTH = 4;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL1 = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_FLAG = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_ENABLE = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_VD_PRIO = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_CU_PRIO = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_WK_PRIO = 6'h14;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h18;
	localparam logic [ADDR_W-1:0] OFF_SRL = 6'h1C;
	localparam logic [ADDR_W-1:0] OFF_TIMED_DISABLE_INSTR = 6'h20;

	// Field positions
	localparam int NEST_BIT = 15;
	localparam int VD_LSB = 0;
	localparam int CU_LSB = 4;
	localparam int WK_LSB = 0;
	localparam int STAT_UNACK = 15;
	localparam int STAT_VECTOR_HOLD_SELECT = 13;
	localparam int STAT_LEVEL_LSB = 8;
	localparam int SRL_IPL_LSB = 1;
	localparam int SRL_TRAP_BIT = 8;

	// User source order inside the user groups
	localparam int SRC_VD = 0;
	localparam int SRC_CU = 1;
	localparam int SRC_WK = 2;

	// Levels and reset values
	localparam logic [PRIO_W-1:0] PRIO_RESET = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_OFF = 3'h0;
	localparam logic [LEVEL_W-1:0] USER_MAX_LEVEL = 4'h7;
	localparam logic [LEVEL_W-1:0] TIMED_DISABLE_INSTR_TOP_LEVEL = 4'h6;
	localparam logic [LEVEL_W-1:0] TRAP_TOP_LEVEL = 4'hF;
	localparam logic [LEVEL_W-1:0] NO_LEVEL = 4'h0;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ==== src/pric_top.sv ====
// Priority interrupt controller with AXI4-Lite registers.
// Assumes the core pulses cpu_ack and cpu_return on core_clk.
// Contract
// (RULE_01) Priority field 111 is level 7, 001 level 1, 000 disables.
// (RULE_02) Every source priority field resets to level 4.
// (RULE_03) Unused bits of priority and status registers ignore writes, read 0.
// (RULE_04) Voltage-detect priority sits in bits 2-0; bits 15-3 unused.
// (RULE_05) Charge-unit priority sits in bits 6-4; others unused, read 0.
// (RULE_06) Wake-up priority sits in bits 2-0 with the same encoding.
// (RULE_07) Status bit 15 reads 1 while an unacknowledged request exists.
// (RULE_08) Vector hold 1 shows highest pending, 0 the last acknowledged.
// (RULE_09) Four-bit field shows the new CPU level 0 to 15 in binary.
// (RULE_10) Seven-bit vector field is vector number minus eight.
// (RULE_11) Nesting disable at control bit 15 stops preemption in service.
// (RULE_12) Software writes priority, clears flag, then sets enable.
// (RULE_13) Pending flag holds until cleared; set flag re-enters after return.
// (RULE_14) Return restores saved status low byte and prior CPU level.
// (RULE_15) Trap flags hold until cleared; set trap is taken again.
// (RULE_16) ORing 0Eh into status low byte gives level 7, blocking users.
// (RULE_17) Only levels up to 7 are maskable; traps 8-15 always taken.
// (RULE_18) Timed disable blocks levels 1-6 for a period, not level 7.
// (RULE_19) Request only for enabled flagged source above CPU level.
// (RULE_20) Among equal top levels the lowest vector wins.
`timescale 1ns/1ps
module pric_top #(
	parameter int STACK_DEPTH = pric_pkg::STACK_DEPTH
) (
	input wire logic core_clk, // System clock
	input wire logic rst_n, // Async reset, active low
	input wire logic [pric_pkg::ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic [2:0] s_axi_awprot, // Unused
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [pric_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic [2:0] s_axi_arprot, // Unused
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [pric_pkg::NUM_USER-1:0] user_event, // Source events
	input wire logic [pric_pkg::NUM_TRAP-1:0] trap_event, // Trap events
	input wire logic cpu_ack, // Core takes presented vector
	input wire logic cpu_return, // Core executes return
	output logic irq_req, // Request to core
	output logic [pric_pkg::LEVEL_W-1:0] irq_level, // Level presented
	output logic [pric_pkg::VEC_W-1:0] irq_vector, // Vector presented
	output logic [pric_pkg::LEVEL_W-1:0] cpu_level // Current CPU level
);
	import pric_pkg::*;

	localparam int DEPTH_W = $clog2(STACK_DEPTH + 1);
	localparam logic [DEPTH_W-1:0] DEPTH_FULL = DEPTH_W'(STACK_DEPTH);

	typedef struct packed {
		logic aw_ok;
		logic [ADDR_W-1:0] aw_addr;
		logic aw_rdy;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic w_rdy;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic nest_dis;
		logic [NUM_TRAP-1:0] trap_flag;
		logic [NUM_USER-1:0] user_flag;
		logic [NUM_USER-1:0] user_en;
		logic [NUM_USER-1:0][PRIO_W-1:0] prio;
		logic vector_hold_select;
		logic [7:0] status_low_byte;
		logic ipl3;
		logic [TIMED_DISABLE_INSTR_W-1:0] timed_disable_instr_cnt;
		logic [DEPTH_W-1:0] depth;
		logic [STACK_DEPTH-1:0][8:0] stack;
		logic req;
		logic [LEVEL_W-1:0] new_cpu_level;
		logic [VEC_W-1:0] req_vec;
		logic [VEC_W-1:0] last_vec;
	} pric_state_t;

	localparam pric_state_t S_RST = '{
		prio: {NUM_USER{PRIO_RESET}}, // [RULE_02]
		default: '0
	};

	pric_state_t s_q;
	pric_state_t s_d;

	logic [LEVEL_W-1:0] cur_lvl;
	logic in_svc;
	logic timed_disable_instr_on;
	logic nest_block;
	wire [NUM_SRC-1:0][LEVEL_W-1:0] src_lvl;
	wire [NUM_SRC-1:0] src_pend;
	wire [NUM_SRC-1:0] src_elig;

	pric_arb_if #(.N(NUM_SRC)) elig_if ();
	pric_arb_if #(.N(NUM_SRC)) pend_if ();

	assign cur_lvl = {s_q.ipl3, s_q.status_low_byte[SRL_IPL_LSB +: PRIO_W]};
	assign in_svc = (s_q.depth != '0);
	assign timed_disable_instr_on = (s_q.timed_disable_instr_cnt != '0);
	assign nest_block = s_q.nest_dis && in_svc; // [RULE_11]

	for (genvar g = 0; g < NUM_SRC; g++)
	begin : g_src
		if (g < NUM_TRAP)
		begin : g_trap
			// Fixed trap levels, highest at the lowest vector
			assign src_lvl[g] = TRAP_TOP_LEVEL - LEVEL_W'(g);
			assign src_pend[g] = s_q.trap_flag[g]; // [RULE_15]
		end
		else
		begin : g_user
			assign src_lvl[g] = {1'b0, s_q.prio[g - NUM_TRAP]}; // [RULE_01]
			assign src_pend[g] = s_q.user_flag[g - NUM_TRAP]
				&& s_q.user_en[g - NUM_TRAP]
				&& (s_q.prio[g - NUM_TRAP] != PRIO_OFF); // [RULE_01]
		end
		// Users are capped at 7, so only traps pass a level-7 mask
		assign src_elig[g] = src_pend[g]
			&& (src_lvl[g] > cur_lvl) // [RULE_19] [RULE_16] [RULE_17]
			&& !(timed_disable_instr_on && src_lvl[g] <= TIMED_DISABLE_INSTR_TOP_LEVEL) // [RULE_18]
			&& !(nest_block && src_lvl[g] <= USER_MAX_LEVEL); // [RULE_11]
	end

	assign elig_if.cand = src_elig;
	assign elig_if.lvl = src_lvl;
	assign pend_if.cand = src_pend;
	assign pend_if.lvl = src_lvl;

	pric_arbiter #(.N(NUM_SRC)) u_elig_arb (
		.arb(elig_if)
	);

	pric_arbiter #(.N(NUM_SRC)) u_pend_arb (
		.arb(pend_if)
	);

	// Read image of one register; bit 16 flags a mapped address
	function automatic logic [16:0] reg_image(
		input logic [ADDR_W-1:0] a,
		input pric_state_t s,
		input logic [VEC_W-1:0] pend_vec
	);
		logic [15:0] d;
		logic hit;
		d = '0; // [RULE_03]
		hit = 1'b1;
		case ({a[ADDR_W-1:2], 2'b00})
			OFF_CTRL1:
			begin
				d[NEST_BIT] = s.nest_dis;
				d[NUM_TRAP-1:0] = s.trap_flag;
			end
			OFF_FLAG: d[NUM_USER-1:0] = s.user_flag;
			OFF_ENABLE: d[NUM_USER-1:0] = s.user_en;
			OFF_VD_PRIO: d[VD_LSB +: PRIO_W] = s.prio[SRC_VD]; // [RULE_04]
			OFF_CU_PRIO: d[CU_LSB +: PRIO_W] = s.prio[SRC_CU]; // [RULE_05]
			OFF_WK_PRIO: d[WK_LSB +: PRIO_W] = s.prio[SRC_WK]; // [RULE_06]
			OFF_STATUS:
			begin
				d[STAT_UNACK] = s.req; // [RULE_07]
				d[STAT_VECTOR_HOLD_SELECT] = s.vector_hold_select;
				d[STAT_LEVEL_LSB +: LEVEL_W] = s.new_cpu_level; // [RULE_09]
				// Field value is the vector number minus eight
				d[VEC_W-1:0] = s.vector_hold_select ? pend_vec : s.last_vec; // [RULE_08] [RULE_10]
			end
			OFF_SRL:
			begin
				d[7:0] = s.status_low_byte;
				d[SRL_TRAP_BIT] = s.ipl3;
			end
			OFF_TIMED_DISABLE_INSTR: d[TIMED_DISABLE_INSTR_W-1:0] = s.timed_disable_instr_cnt;
			default: hit = 1'b0;
		endcase
		return {hit, d};
	endfunction

	logic [16:0] wr_img;
	logic [16:0] rd_img;
	logic [15:0] wr_mask;
	logic [15:0] wr_val;
	logic wr_go;
	logic ack_take;
	logic ret_take;
	logic srl_write;

	always_comb
	begin
		s_d = s_q;
		wr_img = reg_image(s_q.aw_addr, s_q, pend_if.best_idx);
		rd_img = reg_image(s_axi_araddr, s_q, pend_if.best_idx);
		wr_mask = {{8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
		wr_val = (wr_img[15:0] & ~wr_mask) | (s_q.w_data[15:0] & wr_mask);
		wr_go = s_q.aw_ok && s_q.w_ok;
		srl_write = wr_go && ({s_q.aw_addr[ADDR_W-1:2], 2'b00} == OFF_SRL);
		ack_take = cpu_ack && s_q.req;
		ret_take = cpu_return && in_svc && !ack_take;

		// Write channel capture
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (s_axi_awvalid && s_q.aw_rdy)
		begin
			s_d.aw_ok = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.w_rdy)
		begin
			s_d.w_ok = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end

		// Timed disable runs down one per cycle
		if (timed_disable_instr_on)
			s_d.timed_disable_instr_cnt = s_q.timed_disable_instr_cnt - TIMED_DISABLE_INSTR_W'(1); // [RULE_18]

		// Register write; read-only and unused bits are dropped
		if (wr_go)
		begin
			s_d.aw_ok = 1'b0;
			s_d.w_ok = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_img[16] ? RESP_OKAY : RESP_SLVERR;
			case ({s_q.aw_addr[ADDR_W-1:2], 2'b00})
				OFF_CTRL1:
				begin
					s_d.nest_dis = wr_val[NEST_BIT];
					s_d.trap_flag = wr_val[NUM_TRAP-1:0];
				end
				OFF_FLAG: s_d.user_flag = wr_val[NUM_USER-1:0];
				OFF_ENABLE: s_d.user_en = wr_val[NUM_USER-1:0];
				OFF_VD_PRIO: s_d.prio[SRC_VD] = wr_val[VD_LSB +: PRIO_W]; // [RULE_04]
				OFF_CU_PRIO: s_d.prio[SRC_CU] = wr_val[CU_LSB +: PRIO_W]; // [RULE_05]
				OFF_WK_PRIO: s_d.prio[SRC_WK] = wr_val[WK_LSB +: PRIO_W]; // [RULE_06]
				OFF_STATUS: s_d.vector_hold_select = wr_val[STAT_VECTOR_HOLD_SELECT]; // [RULE_03]
				OFF_SRL: s_d.status_low_byte = wr_val[7:0]; // [RULE_16]
				OFF_TIMED_DISABLE_INSTR: s_d.timed_disable_instr_cnt = wr_val[TIMED_DISABLE_INSTR_W-1:0]; // [RULE_18]
				default: s_d.bresp = RESP_SLVERR;
			endcase
		end

		// New events win over a clear in the same cycle
		s_d.user_flag = s_d.user_flag | user_event; // [RULE_13]
		s_d.trap_flag = s_d.trap_flag | trap_event; // [RULE_15]

		// Acknowledge saves status and raises the CPU level
		if (ack_take)
		begin
			if (s_q.depth == DEPTH_FULL)
				s_d.stack[s_q.depth - DEPTH_W'(1)] = {s_d.ipl3, s_d.status_low_byte};
			else
			begin
				s_d.stack[s_q.depth] = {s_d.ipl3, s_d.status_low_byte};
				s_d.depth = s_q.depth + DEPTH_W'(1);
			end
			s_d.status_low_byte[SRL_IPL_LSB +: PRIO_W] = s_q.new_cpu_level[PRIO_W-1:0];
			s_d.ipl3 = s_q.new_cpu_level[LEVEL_W-1];
			s_d.last_vec = s_q.req_vec; // [RULE_08]
		end
		else if (ret_take)
		begin
			// Saved level comes back; a still-set flag asks again
			{s_d.ipl3, s_d.status_low_byte} = s_q.stack[s_q.depth - DEPTH_W'(1)]; // [RULE_14]
			s_d.depth = s_q.depth - DEPTH_W'(1);
		end

		// Request is held off one cycle after an acknowledge or a status low byte write
		s_d.req = elig_if.found && !ack_take && !srl_write; // [RULE_19] [RULE_07]
		s_d.new_cpu_level = elig_if.found ? elig_if.best_lvl : NO_LEVEL; // [RULE_09]
		s_d.req_vec = elig_if.best_idx; // [RULE_20]

		// Read channel
		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.ar_rdy)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = {16'h0000, rd_img[15:0]};
			s_d.rresp = rd_img[16] ? RESP_OKAY : RESP_SLVERR;
		end

		s_d.aw_rdy = !s_d.aw_ok && !s_d.bvalid;
		s_d.w_rdy = !s_d.w_ok && !s_d.bvalid;
		s_d.ar_rdy = !s_d.rvalid;
	end

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= S_RST;
		else
			s_q <= s_d;
	end

	assign s_axi_awready = s_q.aw_rdy;
	assign s_axi_wready = s_q.w_rdy;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.ar_rdy;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign irq_req = s_q.req;
	assign irq_level = s_q.new_cpu_level;
	assign irq_vector = s_q.req_vec;
	assign cpu_level = {s_q.ipl3, s_q.status_low_byte[SRL_IPL_LSB +: PRIO_W]};

endmodule

// ==== verification/pric_core_model.sv ====
// Core model: acknowledges requests, returns on command.
// Assumes registered controller outputs on core_clk.
`timescale 1ns/1ps
module pric_core_model (
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic irq_req, // Request
	input wire logic ack_en, // Accept requests
	input wire logic slow, // Wait three cycles
	input wire logic ret_cmd, // Do a return
	output logic cpu_ack, // Take vector
	output logic cpu_return // Return pulse
);
	logic [1:0] wait_q;

	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cpu_ack <= 1'h0;
			cpu_return <= 1'h0;
			wait_q <= 2'h0;
		end
		else
		begin
			cpu_ack <= 1'h0;
			cpu_return <= ret_cmd;
			wait_q <= 2'h0;
			// Ack only a standing request, never beside a return
			if (!ret_cmd && ack_en && irq_req && !cpu_ack)
			begin
				if (wait_q == (slow ? 2'h3 : 2'h0))
					cpu_ack <= 1'h1;
				else
					wait_q <= wait_q + 2'h1;
			end
		end
	end
endmodule

// ==== verification/pric_props.sv ====
// Port checker of the priority interrupt controller.
// Assumes it is bound into pric_top.
`timescale 1ns/1ps
module pric_props (
	input wire logic core_clk, // Clock
	input wire logic rst_n, // Reset, active low
	input wire logic [pric_pkg::ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_rvalid, // Read valid
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic cpu_ack, // Core ack
	input wire logic irq_req, // Request
	input wire logic [pric_pkg::LEVEL_W-1:0] irq_level, // Request level
	input wire logic [pric_pkg::VEC_W-1:0] irq_vector, // Request vector
	input wire logic [pric_pkg::LEVEL_W-1:0] cpu_level // CPU level
);
	import pric_pkg::*;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	a_vd_field: assert property (
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_VD_PRIO
		|-> s_axi_rdata[31:3] == '0) else $error("stray priority bits");
	a_status_req: assert property (
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_STATUS
		|-> s_axi_rdata[15] == $past(irq_req)) else $error("bad unacked bit");
	a_status_level: assert property (
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == OFF_STATUS
		|-> s_axi_rdata[11:8] == $past(irq_level) && s_axi_rdata[14] == 1'h0
		&& s_axi_rdata[12] == 1'h0 && s_axi_rdata[7] == 1'h0)
		else $error("bad status level");
	a_ack_drops: assert property (
		cpu_ack && irq_req |=> !irq_req) else $error("request kept after ack");
	a_ack_level: assert property (
		cpu_ack && irq_req |=> cpu_level == $past(irq_level))
		else $error("level not taken on ack");
	a_req_above: assert property (
		irq_req && $stable(cpu_level) |-> irq_level > cpu_level)
		else $error("request not above level");
	a_trap_level: assert property (
		irq_req && irq_vector < 7'h04
		|-> irq_level == TRAP_TOP_LEVEL - irq_vector[3:0])
		else $error("bad trap level");
	a_user_masked: assert property (
		irq_req && $stable(cpu_level) && cpu_level == USER_MAX_LEVEL
		|-> irq_vector < 7'h04) else $error("user source not masked");
endmodule

bind pric_top pric_props u_props (.core_clk, .rst_n, .s_axi_araddr,
	.s_axi_rvalid, .s_axi_rdata, .cpu_ack, .irq_req, .irq_level,
	.irq_vector, .cpu_level);

// ==== verification/priority_interrupt_control_bench.sv ====
// Bench of the priority interrupt controller.
// Assumes the core model and the bound checker.
`timescale 1ns/1ps
module priority_interrupt_control_bench;
	import pric_pkg::*;

	logic core_clk = 1'h0, rst_n = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [NUM_USER-1:0] user_event = '0;
	logic [NUM_TRAP-1:0] trap_event = '0;
	logic ack_en = 1'h0, slow = 1'h0, ret_cmd = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cpu_ack, cpu_return, irq_req;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [1:0] b_resp = 2'h0;
	logic [LEVEL_W-1:0] irq_level, cpu_level;
	logic [VEC_W-1:0] irq_vector;
	int n_errors = 0, n_tests = 0, cyc = 0;

	pric_top #(.STACK_DEPTH(2)) dut (.core_clk, .rst_n, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .user_event, .trap_event, .cpu_ack,
		.cpu_return, .irq_req, .irq_level, .irq_vector, .cpu_level);
	pric_core_model core (.core_clk, .rst_n, .irq_req, .ack_en, .slow,
		.ret_cmd, .cpu_ack, .cpu_return);

	initial
		forever #4 core_clk = ~core_clk;

	task automatic stop_test();
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0, d};
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		while (!s_axi_bvalid)
			@(posedge core_clk);
		b_resp = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
			@(posedge core_clk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do
			@(posedge core_clk);
		while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask

	task automatic rc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk($sformatf("reg %h", a), e, d);
	endtask

	task automatic ev(input logic [2:0] u, input logic [3:0] t);
		@(posedge core_clk);
		user_event <= u;
		trap_event <= t;
		@(posedge core_clk);
		user_event <= 3'h0;
		trap_event <= 4'h0;
	endtask

	task automatic wq(input logic v);
		for (int i = 0; i < 100 && irq_req !== v; i++)
			@(negedge core_clk);
		chk("irq_req", v, irq_req);
	endtask

	task automatic wl(input logic [LEVEL_W-1:0] l);
		for (int i = 0; i < 50 && cpu_level !== l; i++)
			@(negedge core_clk);
		chk("cpu_level", l, cpu_level);
	endtask

	task automatic ack(input logic s, input logic [LEVEL_W-1:0] l);
		@(posedge core_clk);
		ack_en <= 1'h1;
		slow <= s;
		wl(l);
		@(posedge core_clk);
		ack_en <= 1'h0;
	endtask

	task automatic ret(input logic [LEVEL_W-1:0] l);
		@(posedge core_clk);
		ret_cmd <= 1'h1;
		@(posedge core_clk);
		ret_cmd <= 1'h0;
		wl(l);
	endtask

	task automatic t_regs();
		logic [31:0] d;
		logic [1:0] r;
		rc(OFF_VD_PRIO, 32'h4);
		rc(OFF_CU_PRIO, 32'h40);
		rc(OFF_WK_PRIO, 32'h4);
		rc(OFF_STATUS, 32'h0);
		wr(OFF_VD_PRIO, 16'hFFFF);
		rc(OFF_VD_PRIO, 32'h7);
		wr(OFF_CU_PRIO, 16'hFFFF);
		rc(OFF_CU_PRIO, 32'h70);
		wr(OFF_WK_PRIO, 16'hFFF8);
		rc(OFF_WK_PRIO, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			wr(OFF_VD_PRIO, 16'(i));
			rc(OFF_VD_PRIO, 32'(i));
		end
		rd(6'h3C, d, r);
		chk("unmapped", {30'h0, RESP_SLVERR}, {d[29:0], r});
		wr(6'h3C, 16'h1);
		chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, b_resp});
	endtask

	task automatic t_service();
		wr(OFF_VD_PRIO, 16'h3);
		wr(OFF_FLAG, 16'h0);
		wr(OFF_ENABLE, 16'h1);
		ev(3'h1, 4'h0);
		wq(1'h1);
		chk("irq_vector", 32'h4, irq_vector);
		wr(OFF_STATUS, 16'h2000);
		rc(OFF_STATUS, 32'hA304);
		ack(1'h0, 4'h3);
		wr(OFF_STATUS, 16'h0);
		rc(OFF_STATUS, 32'h4);
		ret(4'h0);
		wq(1'h1);
		wr(OFF_FLAG, 16'h0);
		wq(1'h0);
		wr(OFF_VD_PRIO, 16'h0);
		wr(OFF_FLAG, 16'h1);
		repeat (4) @(negedge core_clk);
		chk("irq_req", 32'h0, irq_req);
	endtask

	task automatic t_mask();
		wr(OFF_VD_PRIO, 16'h5);
		wr(OFF_CU_PRIO, 16'h50);
		wr(OFF_ENABLE, 16'h3);
		wr(OFF_FLAG, 16'h3);
		wq(1'h1);
		chk("irq_vector", 32'h4, irq_vector);
		wr(OFF_CU_PRIO, 16'h60);
		repeat (3) @(negedge core_clk);
		chk("irq_vector", 32'h5, irq_vector);
		wr(OFF_SRL, 16'hE);
		wq(1'h0);
		chk("cpu_level", 32'h7, cpu_level);
		ev(3'h0, 4'h2);
		wq(1'h1);
		chk("trap", 32'h01E, {irq_vector, irq_level});
		ack(1'h1, 4'hE);
		ret(4'h7);
		wq(1'h1);
		chk("irq_vector", 32'h1, irq_vector);
		wr(OFF_CTRL1, 16'h0);
		wq(1'h0);
	endtask

	task automatic t_timed_disable_instr_nest();
		wr(OFF_SRL, 16'h0);
		wr(OFF_TIMED_DISABLE_INSTR, 16'd40);
		wq(1'h0);
		wr(OFF_VD_PRIO, 16'h7);
		wq(1'h1);
		chk("irq_vector", 32'h4, irq_vector);
		wr(OFF_VD_PRIO, 16'h5);
		@(negedge core_clk);
		chk("irq_req", 32'h0, irq_req);
		wq(1'h1);
		wr(OFF_CU_PRIO, 16'h0);
		wr(OFF_CTRL1, 16'h8000);
		ack(1'h0, 4'h5);
		wr(OFF_CU_PRIO, 16'h60);
		repeat (4) @(negedge core_clk);
		chk("irq_req", 32'h0, irq_req);
		wr(OFF_CTRL1, 16'h0);
		wq(1'h1);
		chk("irq_vector", 32'h5, irq_vector);
	endtask

	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			n_errors++;
			stop_test();
		end
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'h1;
		@(posedge core_clk);
		t_regs();
		t_service();
		t_mask();
		t_timed_disable_instr_nest();
		stop_test();
	end
endmodule
